// ==== include/dpb_pkg.sv ====
`default_nettype none
package dpb_pkg;

  // Bus clock period in picoseconds (40 MHz)
  localparam int CLK_PERIOD_PS = 25000;

  // Strobe timing minima in ns
  localparam int STORE_LOW_MIN_NS = 50;
  localparam int STORE_HIGH_MIN_NS = 50;
  localparam int STORE_CYCLE_MIN_NS = 100;
  localparam int FETCH_LOW_MIN_NS = 150;
  localparam int FETCH_HIGH_MIN_NS = 150;
  localparam int FETCH_CYCLE_MIN_NS = 300;
  // Write data setup before the rising store edge, in ns
  localparam int STORE_SETUP_MIN_NS = 25;
  // Panel init strobe low time in ns (plain default)
  localparam int INIT_LOW_NS = 10000;

  // Least-time rounding: round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Phase counts in cycles
  localparam int STORE_LOW_CYC = ns_to_cyc(STORE_LOW_MIN_NS);
  localparam int STORE_HIGH_CYC =
    (ns_to_cyc(STORE_HIGH_MIN_NS) + STORE_LOW_CYC
     < ns_to_cyc(STORE_CYCLE_MIN_NS)) ?
    ns_to_cyc(STORE_CYCLE_MIN_NS) - STORE_LOW_CYC :
    ns_to_cyc(STORE_HIGH_MIN_NS);
  localparam int FETCH_LOW_CYC = ns_to_cyc(FETCH_LOW_MIN_NS);
  localparam int FETCH_HIGH_CYC =
    (ns_to_cyc(FETCH_HIGH_MIN_NS) + FETCH_LOW_CYC
     < ns_to_cyc(FETCH_CYCLE_MIN_NS)) ?
    ns_to_cyc(FETCH_CYCLE_MIN_NS) - FETCH_LOW_CYC :
    ns_to_cyc(FETCH_HIGH_MIN_NS);
  localparam int INIT_LOW_CYC = ns_to_cyc(INIT_LOW_NS);

  // Counter width and reset values
  localparam int CNT_W = 16;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Access request as issued by the user side
  typedef struct packed {
    logic rd;
    logic reg_sel;
    logic [15:0] wdata;
  } dpb_req_t;

  // Panel data pin pair: out and enable
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } dpb_pin_t;

endpackage

`default_nettype wire

// ==== core/dpb_master.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - One 16-bit two-way bus for all data
// - Select low for whole access, else high
// - Register select low index, high data
// - Store strobe pulses low with word driven
// - Fetch strobe pulses low, panel returns word
// - Init strobe pulses low to reset panel
// - Boost supply enable follows user control
// - Store phases 50 ns, cycle 100 ns
// - Fetch phases 150 ns, cycle 300 ns
module dpb_master
  import dpb_pkg::*;
#(
  parameter int DW = 16 // Panel data width
) (
  input wire logic CLK, // 40 MHz clock
  input wire logic RST, // Sync reset, high
  input wire logic REQ_VALID, // Access request
  input wire dpb_req_t REQ, // Request fields
  output logic REQ_READY, // Idle, request taken
  output logic [DW-1:0] RDATA, // Last word fetched
  output logic RDATA_VALID, // Fetch done pulse
  input wire logic INIT_START, // Start panel init pulse
  input wire logic BOOST_EN, // Boost supply request
  output logic boost_supply_on, // Boost supply pin
  output logic panel_init_strobe_n, // Panel reset pin
  output logic PANEL_SEL_N, // Panel select pin
  output logic register_select, // Register select pin
  output logic STORE_N, // Write strobe pin
  output logic FETCH_N, // Read strobe pin
  input wire logic [DW-1:0] PANEL_DATA_I, // Data bus in
  output logic [DW-1:0] PANEL_DATA_O, // Data bus out
  output logic [DW-1:0] PANEL_DATA_OE // Data bus enable
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  // Sequencer, counter and bus drive state

  // Sequencer states, one per strobe phase
  typedef enum logic [2:0] {
    ST_IDLE, // Waiting, select high
    ST_WLOW, // Store strobe low
    ST_WHIGH, // Store strobe high
    ST_RLOW, // Fetch strobe low
    ST_RHIGH, // Fetch strobe high
    ST_INIT // Panel init pulse low
  } dpb_state_t;

  dpb_state_t state_reg; // Access sequencer state
  logic [CNT_W-1:0] cnt_reg; // Phase cycle counter
  logic [DW-1:0] wdata_reg; // Word being stored
  logic drive_reg; // Bus drive enable
  logic last; // Current phase ends
  // Phase lengths come from the package
  // Store 2 + 2, fetch 6 + 6 cycles at 40 MHz

  // Count reaching a phase length
  // Counter starts at zero, so last count is n - 1
  function automatic logic phase_done(input logic [CNT_W-1:0] c,
                                      input int n);
    return c == CNT_W'(n - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  // Phase end decode
  // High on the last cycle of a timed phase
  // Never high while idle
  always_comb begin
    case (state_reg)
      // Store phases
      ST_WLOW: last = phase_done(cnt_reg, STORE_LOW_CYC);
      ST_WHIGH: last = phase_done(cnt_reg, STORE_HIGH_CYC);
      // Fetch phases
      ST_RLOW: last = phase_done(cnt_reg, FETCH_LOW_CYC);
      ST_RHIGH: last = phase_done(cnt_reg, FETCH_HIGH_CYC);
      // Init pulse
      ST_INIT: last = phase_done(cnt_reg, INIT_LOW_CYC);
      // Idle has no timed phase
      default: last = 1'b0;
    endcase
  end

  // Ready only when idle, init not pending
  // A pending init holds off new accesses
  assign REQ_READY = (state_reg == ST_IDLE) && !INIT_START;

  // State and phase counter
  // Counter clears at phase end and in idle
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else begin
      // Count cycles within the phase
      cnt_reg <= last ? '0 :
                 (state_reg == ST_IDLE) ? '0 : cnt_reg + 1'b1;
      case (state_reg)
        ST_IDLE: begin
          // Init has priority over accesses
          if (INIT_START) begin
            state_reg <= ST_INIT;
          end else if (REQ_VALID) begin
            // Direction from the request
            state_reg <= REQ.rd ? ST_RLOW : ST_WLOW;
          end
        end
        ST_WLOW: if (last) state_reg <= ST_WHIGH;
        ST_WHIGH: if (last) state_reg <= ST_IDLE;
        ST_RLOW: if (last) state_reg <= ST_RHIGH;
        ST_RHIGH: if (last) state_reg <= ST_IDLE;
        // Back to idle after the init pulse
        ST_INIT: if (last) state_reg <= ST_IDLE;
        // Unused codes fall back to idle
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin control
  //
  // Write: select and store low together, word driven
  // Store rises after its low phase, select after high
  // Read: select and fetch low, bus released
  // Word taken on the last fetch-low cycle
  // Select high for one idle cycle between accesses
  // That idle cycle also parts store drive from fetch

  // Select, register select and strobes from state
  // Every pin from a flip-flop, so no glitches
  always_ff @(posedge CLK) begin
    if (RST) begin
      // All strobes and select released
      PANEL_SEL_N <= 1'b1;
      register_select <= 1'b1;
      STORE_N <= 1'b1;
      FETCH_N <= 1'b1;
      panel_init_strobe_n <= 1'b1;
    end else begin
      // Access taken this cycle
      if (state_reg == ST_IDLE && !INIT_START && REQ_VALID) begin
        PANEL_SEL_N <= 1'b0;
        register_select <= REQ.reg_sel;
        STORE_N <= REQ.rd;
        FETCH_N <= !REQ.rd;
      end else if (last) begin
        // Strobes rise at every phase end
        STORE_N <= 1'b1;
        FETCH_N <= 1'b1;
        if (state_reg == ST_WHIGH || state_reg == ST_RHIGH)
          PANEL_SEL_N <= 1'b1;
      end
      // Init pulse starts from idle only
      // init strobe low pulse
      if (state_reg == ST_IDLE && INIT_START)
        panel_init_strobe_n <= 1'b0;
      else if (state_reg == ST_INIT && last)
        panel_init_strobe_n <= 1'b1;
    end
  end

  // Data drive for writes only
  // Word latched at take, held to cycle end
  always_ff @(posedge CLK) begin
    if (RST) begin
      // Bus released in reset
      wdata_reg <= DATA_RST;
      drive_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && !INIT_START && REQ_VALID) begin
      wdata_reg <= REQ.wdata;
      drive_reg <= !REQ.rd;
    end else if (state_reg == ST_WHIGH && last) begin
      // Released with select at write end
      drive_reg <= 1'b0;
    end
  end

  // Out and enable straight from flip-flops
  // one shared bus, driven on writes
  assign PANEL_DATA_O = wdata_reg;
  assign PANEL_DATA_OE = {DW{drive_reg}};

  // Capture panel word at end of fetch low
  // Panel word still stands before the strobe rises
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= DATA_RST;
      RDATA_VALID <= 1'b0;
    end else begin
      // One valid pulse per read
      // capture at strobe rise
      RDATA_VALID <= (state_reg == ST_RLOW) && last;
      if (state_reg == ST_RLOW && last)
        RDATA <= PANEL_DATA_I;
    end
  end

  // Follows the user request one cycle late
  // boost supply enable
  always_ff @(posedge CLK) begin
    if (RST)
      boost_supply_on <= 1'b0;
    else
      boost_supply_on <= BOOST_EN;
  end

endmodule // dpb_master

`default_nettype wire

// ==== verif/dpb_master_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpb_master_sva import dpb_pkg::*; (
  input wire logic CLK, // Clock
  input wire logic RST, // Reset
  input wire logic REQ_VALID, // Request
  input wire dpb_req_t REQ, // Fields
  input wire logic REQ_READY, // Idle
  input wire logic PANEL_SEL_N, // Select
  input wire logic register_select, // Reg sel
  input wire logic STORE_N, // Store
  input wire logic FETCH_N, // Fetch
  input wire logic [15:0] PANEL_DATA_OE // Enable
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_store_low: assert property (
    $fell(STORE_N) |=> !STORE_N ##1 STORE_N) else $error("store low");
  a_store_high: assert property (
    $rose(STORE_N) |-> STORE_N[*2]) else $error("store high");
  a_fetch_low: assert property (
    $fell(FETCH_N) |-> !FETCH_N[*6] ##1 FETCH_N) else $error("fetch low");
  a_fetch_high: assert property (
    $rose(FETCH_N) |-> FETCH_N[*6]) else $error("fetch high");
  a_take_sel: assert property (
    REQ_VALID && REQ_READY |=> !PANEL_SEL_N
    && register_select == $past(REQ.reg_sel)) else $error("take");
  a_sel_strobe: assert property (
    !STORE_N || !FETCH_N |-> !PANEL_SEL_N) else $error("select");
  a_store_drive: assert property (
    !STORE_N |-> PANEL_DATA_OE == 16'hffff) else $error("store drive");
  a_fetch_release: assert property (
    !FETCH_N |-> PANEL_DATA_OE == 16'h0000) else $error("fetch drive");
  cover property ($fell(STORE_N));
  cover property ($fell(FETCH_N));
  cover property (REQ_VALID && REQ_READY);
endmodule // dpb_master_sva
bind dpb_master dpb_master_sva u_sva (
  .CLK(CLK),
  .RST(RST),
  .REQ_VALID(REQ_VALID),
  .REQ(REQ),
  .REQ_READY(REQ_READY),
  .PANEL_SEL_N(PANEL_SEL_N),
  .register_select(register_select),
  .STORE_N(STORE_N),
  .FETCH_N(FETCH_N),
  .PANEL_DATA_OE(PANEL_DATA_OE)
);
`default_nettype wire

// ==== verif/dpb_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpb_panel_model (
  input wire logic CLK, // Clock
  input wire logic PANEL_SEL_N, // Select
  input wire logic STORE_N, // Store
  input wire logic FETCH_N, // Fetch
  input wire logic [15:0] PANEL_DATA_O, // Device word
  input wire logic [15:0] PANEL_DATA_OE, // Device enable
  output logic [15:0] PANEL_DATA_I // Wire level
);
  logic [15:0] mem_reg; // Stored word
  int n; // Fetch low cycles
  always @(posedge CLK) if (!PANEL_SEL_N && !STORE_N) mem_reg <= PANEL_DATA_O;
  always @(posedge CLK) n <= FETCH_N ? 0 : n + 1;
  assign PANEL_DATA_I = |PANEL_DATA_OE ? PANEL_DATA_O :
    !PANEL_SEL_N && !FETCH_N && n > 2 ? mem_reg : ~mem_reg;
endmodule // dpb_panel_model
`default_nettype wire

// ==== verif/display_parallel_bus_master_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module display_parallel_bus_master_test import dpb_pkg::*;;
  logic CLK, RST, REQ_VALID, REQ_READY, RDATA_VALID, INIT_START;
  logic BOOST_EN, boost_supply_on, panel_init_strobe_n, PANEL_SEL_N;
  logic register_select, STORE_N, FETCH_N;
  logic [15:0] RDATA, PANEL_DATA_I, PANEL_DATA_O, PANEL_DATA_OE, stored;
  dpb_req_t REQ;
  integer seed = 32'h22c8_8a32;
  int errors = 0, checked = 0;
  always #12.5 CLK = ~CLK;
  dpb_master DUT (.*);
  dpb_panel_model PANEL (.*);
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge CLK) #1;
  endtask
  // Bench model: a read returns the last word stored, and the
  // phase counts come from the package constants
  task automatic acc(input logic rd, input logic [15:0] w);
    int k;
    int c;
    int seen;
    k = 0;
    c = 0;
    seen = 0;
    REQ_VALID = 1;
    REQ = {rd, w[1], w};
    BOOST_EN = w[2];
    while (!REQ_READY && k < 99) begin
      k++;
      tick;
    end
    chk(16'(REQ_READY), 16'h0001);
    tick;
    REQ_VALID = 0;
    chk(16'(boost_supply_on), 16'(w[2]));
    if (!rd) stored = w;
    while (!REQ_READY && c < 99) begin
      if (RDATA_VALID) begin
        seen++;
        chk(16'(c), 16'(FETCH_LOW_CYC));
        chk(RDATA, stored);
      end
      c++;
      tick;
    end
    chk(16'(seen), 16'(rd));
    if (rd) chk(16'(c), 16'(FETCH_LOW_CYC + FETCH_HIGH_CYC));
    else chk(16'(c), 16'(STORE_LOW_CYC + STORE_HIGH_CYC));
  endtask
  task automatic report_and_stop;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial begin
    CLK = 0;
    RST = 1;
    REQ_VALID = 0;
    REQ = '0;
    INIT_START = 0;
    BOOST_EN = 0;
    repeat (10) tick;
    RST = 0;
    INIT_START = 1;
    tick;
    INIT_START = 0;
    tick;
    chk(16'(panel_init_strobe_n), 16'h0000);
    repeat (INIT_LOW_CYC - 2) tick;
    chk(16'(panel_init_strobe_n), 16'h0000);
    repeat (2) tick;
    chk(16'(panel_init_strobe_n), 16'h0001);
    acc(0, 16'h5aa5);
    for (int i = 0; i < 40; i++) acc(1'($random(seed)), 16'($random(seed)));
    report_and_stop;
  end
endmodule // display_parallel_bus_master_test
`default_nettype wire
